// file: peak_switch_map.svh
/*
 Constants for the peak-detecting switch core: widths, hysteresis,
 gain and offset settings, calibration length.
 Assumes a 10 MHz core clock and a digitised processed signal.
*/
`ifndef PEAK_SWITCH_MAP_SVH
`define PEAK_SWITCH_MAP_SVH

`define SIG_W 10
`define GAIN_W 4
`define FALLING_SWITCH_HYSTERESIS 10'h018
`define RISING_SWITCH_HYSTERESIS 10'h018
`define CAL_RISING_EDGES 2'h3
`define GAIN_RESET 4'h8
`define OFFSET_RESET 10'h000
`define TARGET_PP 10'h100
`define OFFSET_STEP_DIV 4

`endif

// file: peak_switch_pkg.sv
/*
 Types for the peak-detecting switch core.
 Assumes peak_switch_map.svh is compiled alongside.
*/
package peak_switch_pkg;
    typedef enum logic {TRACK_UP, TRACK_DOWN} track_dir_t;
    typedef enum logic {MODE_CAL, MODE_RUN} op_mode_t;
    typedef struct packed {
        logic [3:0] gain;
        logic signed [9:0] offset;
    } trim_t;
endpackage : peak_switch_pkg

// file: peak_detect_switch_core.sv
/*
 Peak-detecting switch core: tracking peak hold, hysteresis switching,
 gain calibration and continuous offset trim.
 Assumes processed_diff_signal_i is a signed sample synchronous to clock_i,
 already scaled and offset-corrected in the front end from trim_o.
*/
`include "peak_switch_map.svh"
module peak_detect_switch_core (
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic clk_en_i,
    // Supply and orientation
    input wire logic undervoltage_i,
    input wire logic reverse_dir_i,
    // Processed signal
    input wire logic signed [`SIG_W-1:0] processed_diff_signal_i,
    // Output current level, 1 = output_current_high
    output logic output_current_high_o,
    // Trim to the front end
    output peak_switch_pkg::trim_t trim_o,
    // Status
    output logic running_o
);
    peak_switch_pkg::track_dir_t dir_q;
    peak_switch_pkg::op_mode_t mode_q;
    logic signed [`SIG_W-1:0] peak_q;
    logic signed [`SIG_W-1:0] cal_max_q;
    logic signed [`SIG_W-1:0] cal_min_q;
    logic [1:0] rise_cnt_q;
    logic [3:0] gain_q;
    logic signed [`SIG_W-1:0] offset_q;
    logic pol_q;
    logic signed [`SIG_W:0] diff;
    logic fall_hit;
    logic rise_hit;
    logic toggle;
    logic cal_done;
    logic signed [`SIG_W:0] centre;
    logic signed [`SIG_W:0] swing;

    // One extra sign bit so sums and differences of two samples cannot wrap
    function automatic logic signed [`SIG_W:0] widen(input logic signed [`SIG_W-1:0] v);
        return $signed({v[`SIG_W-1], v});
    endfunction : widen

    // Compare every cycle against constant hysteresis
    assign diff = widen(peak_q) - widen(processed_diff_signal_i);
    assign fall_hit = (dir_q == peak_switch_pkg::TRACK_UP) && (diff >= $signed({1'b0, `FALLING_SWITCH_HYSTERESIS}));
    assign rise_hit = (dir_q == peak_switch_pkg::TRACK_DOWN) && (-diff >= $signed({1'b0, `RISING_SWITCH_HYSTERESIS}));
    assign toggle = fall_hit || rise_hit;
    // Rising output edge occurs on rise_hit with reference polarity
    assign cal_done = rise_hit && (rise_cnt_q == `CAL_RISING_EDGES - 2'h1);

    // Peak tracker and direction; held value never decays
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dir_q <= peak_switch_pkg::TRACK_UP;
            peak_q <= '0;
        end else if (clk_en_i) begin
            if (undervoltage_i) begin
                dir_q <= peak_switch_pkg::TRACK_UP;
                peak_q <= '0;
            end else if (fall_hit) begin
                dir_q <= peak_switch_pkg::TRACK_DOWN;
                peak_q <= processed_diff_signal_i;
            end else if (rise_hit) begin
                dir_q <= peak_switch_pkg::TRACK_UP;
                peak_q <= processed_diff_signal_i;
            end else if (dir_q == peak_switch_pkg::TRACK_UP && processed_diff_signal_i > peak_q) begin
                peak_q <= processed_diff_signal_i;
            end else if (dir_q == peak_switch_pkg::TRACK_DOWN && processed_diff_signal_i < peak_q) begin
                peak_q <= processed_diff_signal_i;
            end
        end
    end

    // Output level: high at power-on, falls when the upper peak is passed unless pol_q is set, then rises
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            output_current_high_o <= 1'b1;
            pol_q <= 1'b0;
        end else if (clk_en_i) begin
            if (undervoltage_i) begin
                output_current_high_o <= 1'b1;
                pol_q <= reverse_dir_i;
            end else if (toggle) begin
                // Reference: tooth leading edge gives fall_hit, output goes low
                output_current_high_o <= rise_hit ^ pol_q;
            end else if (output_current_high_o == pol_q && dir_q == peak_switch_pkg::TRACK_UP && !pol_q) begin
                output_current_high_o <= output_current_high_o;
            end
        end
    end

    // Calibration sequencing
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_q <= peak_switch_pkg::MODE_CAL;
            rise_cnt_q <= 2'h0;
        end else if (clk_en_i) begin
            if (undervoltage_i) begin
                mode_q <= peak_switch_pkg::MODE_CAL;
                rise_cnt_q <= 2'h0;
            end else begin
                case (mode_q)
                    peak_switch_pkg::MODE_CAL: begin
                        if (rise_hit) begin
                            rise_cnt_q <= rise_cnt_q + 2'h1;
                        end
                        if (cal_done) begin
                            mode_q <= peak_switch_pkg::MODE_RUN;
                        end
                    end
                    peak_switch_pkg::MODE_RUN: begin
                        rise_cnt_q <= rise_cnt_q;
                    end
                    default: begin
                        mode_q <= peak_switch_pkg::MODE_CAL;
                    end
                endcase
            end
        end
    end

    // Amplitude measurement and gain; a full-scale swing needs 11 bits
    assign swing = widen(cal_max_q) - widen(cal_min_q);
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cal_max_q <= '0;
            cal_min_q <= '0;
            gain_q <= `GAIN_RESET;
        end else if (clk_en_i) begin
            if (undervoltage_i) begin
                cal_max_q <= '0;
                cal_min_q <= '0;
                gain_q <= `GAIN_RESET;
            end else if (mode_q == peak_switch_pkg::MODE_CAL) begin
                if (processed_diff_signal_i > cal_max_q) cal_max_q <= processed_diff_signal_i;
                if (processed_diff_signal_i < cal_min_q) cal_min_q <= processed_diff_signal_i;
                if (rise_hit) begin
                    // Coarse one-step gain move per cycle of the target
                    if (swing < $signed({1'b0, `TARGET_PP}) && gain_q != 4'hf) begin
                        gain_q <= gain_q + 4'h1;
                    end else if (swing > $signed({1'b0, `TARGET_PP}) && gain_q != 4'h0) begin
                        gain_q <= gain_q - 4'h1;
                    end
                    cal_max_q <= '0;
                    cal_min_q <= '0;
                end
            end
        end
    end

    // Offset trim from the midpoint of the held lower peak and the sample at each rise switch
    assign centre = (widen(peak_q) + widen(processed_diff_signal_i)) >>> 1;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            offset_q <= `OFFSET_RESET;
        end else if (clk_en_i) begin
            if (undervoltage_i) begin
                offset_q <= `OFFSET_RESET;
            end else if (rise_hit) begin
                // Full recentre during calibration, slow step in running mode
                if (mode_q == peak_switch_pkg::MODE_CAL) begin
                    offset_q <= offset_q - centre[`SIG_W-1:0];
                end else begin
                    // Signed shift, or a negative centre would step the wrong way
                    offset_q <= offset_q - ($signed(centre[`SIG_W-1:0]) >>> `OFFSET_STEP_DIV);
                end
            end
        end
    end

    assign trim_o = '{gain: gain_q, offset: offset_q};
    assign running_o = (mode_q == peak_switch_pkg::MODE_RUN);

    a_fall_switch: assert property (@(posedge clock_i) disable iff (!resetn_i)
        clk_en_i && !undervoltage_i && fall_hit |=> dir_q == peak_switch_pkg::TRACK_DOWN)
        else $error("no downward tracking after fall");
    a_rise_switch: assert property (@(posedge clock_i) disable iff (!resetn_i)
        clk_en_i && !undervoltage_i && rise_hit |=> dir_q == peak_switch_pkg::TRACK_UP)
        else $error("no upward tracking after rise");
    a_peak_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
        clk_en_i && !undervoltage_i && !toggle && dir_q == peak_switch_pkg::TRACK_UP
        |=> peak_q >= $past(peak_q))
        else $error("upper peak dropped");
    a_peak_nodecay: assert property (@(posedge clock_i) disable iff (!resetn_i)
        !clk_en_i |=> $stable(peak_q))
        else $error("peak changed while frozen");
    a_uv_output: assert property (@(posedge clock_i) disable iff (!resetn_i)
        clk_en_i && undervoltage_i |=> output_current_high_o && !running_o)
        else $error("undervoltage did not restore power-on state");
    a_out_edge: assert property (@(posedge clock_i) disable iff (!resetn_i)
        clk_en_i && !undervoltage_i && fall_hit && !pol_q |=> !output_current_high_o)
        else $error("reference fall did not drive low");
    a_out_reverse: assert property (@(posedge clock_i) disable iff (!resetn_i)
        clk_en_i && !undervoltage_i && fall_hit && pol_q |=> output_current_high_o)
        else $error("reversed fall not inverted");
    a_cal_end: assert property (@(posedge clock_i) disable iff (!resetn_i)
        clk_en_i && !undervoltage_i && cal_done |=> running_o)
        else $error("calibration did not end");
    a_gain_run: assert property (@(posedge clock_i) disable iff (!resetn_i)
        running_o && $past(running_o) |-> $stable(gain_q))
        else $error("gain moved in running mode");
    a_fall_margin: assert property (@(posedge clock_i) disable iff (!resetn_i)
        clk_en_i && !undervoltage_i && dir_q == peak_switch_pkg::TRACK_UP
        && widen(peak_q) - widen(processed_diff_signal_i) < $signed({1'b0, `FALLING_SWITCH_HYSTERESIS})
        |=> $stable(output_current_high_o))
        else $error("output moved inside falling hysteresis");
    a_rise_margin: assert property (@(posedge clock_i) disable iff (!resetn_i)
        clk_en_i && !undervoltage_i && dir_q == peak_switch_pkg::TRACK_DOWN
        && widen(processed_diff_signal_i) - widen(peak_q) < $signed({1'b0, `RISING_SWITCH_HYSTERESIS})
        |=> $stable(output_current_high_o))
        else $error("output moved inside rising hysteresis");
    a_gain_down: assert property (@(posedge clock_i) disable iff (!resetn_i)
        clk_en_i && !undervoltage_i && !running_o && rise_hit
        && swing > $signed({1'b0, `TARGET_PP}) && gain_q != 4'h0 |=> gain_q == $past(gain_q) - 4'h1)
        else $error("large swing did not lower gain");
    a_run_edge: assert property (@(posedge clock_i) disable iff (!resetn_i)
        clk_en_i && !undervoltage_i && running_o && toggle |=> $changed(output_current_high_o))
        else $error("peak gave no output edge in running mode");
    c_run_mode: cover property (@(posedge clock_i) disable iff (!resetn_i) $rose(running_o));
    c_fall_hit: cover property (@(posedge clock_i) disable iff (!resetn_i) clk_en_i && fall_hit);
    c_uv_reset: cover property (@(posedge clock_i) disable iff (!resetn_i) running_o ##1 undervoltage_i);
    c_rev_fall: cover property (@(posedge clock_i) disable iff (!resetn_i) clk_en_i && fall_hit && pol_q);
    c_run_rise: cover property (@(posedge clock_i) disable iff (!resetn_i) clk_en_i && running_o && rise_hit);
endmodule : peak_detect_switch_core

// file: gear_target_model.sv
/*
 Far side of the switch core: a ferrous target seen as a triangle wave on the
 processed signal, and a current receiver that counts output level changes.
 Assumes the map header and a free-running core clock.
*/
`include "peak_switch_map.svh"
module gear_target_model (
    // Clock and control
    input wire logic clock_i,
    input wire logic run_i,
    input wire logic signed [`SIG_W-1:0] amp_i,
    input wire logic signed [`SIG_W-1:0] step_i,
    // Receiver side
    input wire logic level_i,
    // Target sample and receiver count
    output logic signed [`SIG_W-1:0] sample_o,
    output logic [15:0] edges_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic up_q;
    logic level_q;
    always_ff @(posedge clock_i) begin
        if (!run_i) begin
            sample_o <= '0;
            up_q <= 1'b1;
        end else if (up_q) begin
            if (sample_o + step_i >= amp_i) up_q <= 1'b0;
            sample_o <= sample_o + step_i;
        end else begin
            if (sample_o - step_i <= -amp_i) up_q <= 1'b1;
            sample_o <= sample_o - step_i;
        end
    end
    // Receiver sees every level change, no filtering
    // Plain always, as the counter also takes its start value here
    initial begin
        edges_o = 16'h0000;
        level_q = 1'b1;
    end
    always @(posedge clock_i) begin
        level_q <= level_i;
        if (level_q !== level_i) edges_o <= edges_o + 16'h0001;
    end
endmodule : gear_target_model

// file: peak_detect_switch_core_tb.sv
/*
 Self-checking bench for the peak-detecting switch core.
 Assumes the design, its package and header, and gear_target_model.
*/
`include "peak_switch_map.svh"
module peak_detect_switch_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, uv = 1'b0, rev = 1'b0, use_model = 1'b0, level, running;
    logic signed [`SIG_W-1:0] man_q = '0, model_s, o0;
    peak_switch_pkg::trim_t trim;
    logic [15:0] edges, e0;
    int n_mismatch = 0, tests_run = 0, cycles = 0;

    gear_target_model far (.clock_i(clk), .run_i(use_model), .amp_i(10'h100), .step_i(10'h010),
        .level_i(level), .sample_o(model_s), .edges_o(edges));
    peak_detect_switch_core uut (.clock_i(clk), .resetn_i(resetn), .clk_en_i(clk_en),
        .undervoltage_i(uv), .reverse_dir_i(rev),
        .processed_diff_signal_i(use_model ? model_s : man_q),
        .output_current_high_o(level), .trim_o(trim), .running_o(running));

    initial begin
        forever #50 clk = ~clk;
    end
    // Whole run needs about 1100 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            summarize();
        end
    end

    task summarize();
        if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    task check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task put(input int v, input int n = 1);
        for (int i = 0; i < n; i++) begin
            man_q = 10'(v);
            @(posedge clk);
            #10;
        end
    endtask : put
    task ramp(input int from, input int to, input int st);
        for (int v = from; (st > 0) ? v <= to : v >= to; v += st) put(v);
    endtask : ramp

    task t_hysteresis();
        ramp(32, 256, 32);
        put(233, 2);
        check(level, 1);
        clk_en = 1'b0;
        put(232, 3);
        check(level, 1);
        clk_en = 1'b1;
        put(232, 2);
        check(level, 0);
        check(level, 0);
        ramp(192, -256, -32);
        put(-233, 2);
        check(level, 0);
        put(-232, 2);
        check(level, 1);
        check(trim.gain, 16'h0007);
        check(trim.offset, 16'h00f4);
        put(-232, 200);
        check(level, 1);
        check(running, 0);
    endtask : t_hysteresis
    task t_calibration();
        use_model = 1'b1;
        repeat (200) put(0);
        check(running, 1);
        check(trim.gain < 4'h8, 1);
    endtask : t_calibration
    task t_running();
        e0 = edges;
        o0 = trim.offset;
        repeat (640) put(0);
        check(edges - e0, 16'h0014);
        check(trim.offset != o0, 1);
    endtask : t_running
    task t_undervoltage();
        use_model = 1'b0;
        uv = 1'b1;
        rev = 1'b1;
        put(0, 2);
        check(level, 1);
        check(running, 0);
        check(trim.gain, 4'h8);
        uv = 1'b0;
        rev = 1'b0;
        ramp(64, 256, 64);
        put(232, 2);
        check(level, 1);
    endtask : t_undervoltage

    initial begin
        repeat (8) @(posedge clk);
        #10;
        resetn = 1'b1;
        check(level, 1);
        check(running, 0);
        check(trim, {4'h8, 10'h000});
        t_hysteresis();
        t_calibration();
        t_running();
        t_undervoltage();
        summarize();
    end
endmodule : peak_detect_switch_core_tb
